//--- hw/wdt_pkg.sv
// shared constants, register map and bus carriers for the watchdog
package wdt_pkg;

  // register indices; byte address is four times the index
  localparam int unsigned AW = 18;
  localparam logic [AW-1:0] IDX_PROC_MODE = 18'h00005;
  localparam logic [AW-1:0] IDX_CLK_MODE  = 18'h00007;
  localparam logic [AW-1:0] IDX_REFRESH = 18'h0000d;
  localparam logic [AW-1:0] IDX_START   = 18'h0000e;
  localparam logic [AW-1:0] IDX_CTRL    = 18'h0000f;
  localparam logic [AW-1:0] IDX_COUNT   = 18'h00010;
  localparam logic [AW-1:0] IDX_PROTECT = 18'h0001c;
  localparam logic [AW-1:0] IDX_OPTION  = 18'h0ffff;
  localparam int unsigned IDX_LSB = 2;

  // field positions
  localparam int unsigned PRESCALE_SEL_POS = 7;
  localparam int unsigned UF_RESET_SEL_POS = 2;
  localparam int unsigned STOP_MODE_POS    = 0;
  localparam int unsigned LOSC_STOP_POS    = 4;
  localparam int unsigned PROTECT_EN_POS   = 7;
  localparam int unsigned AUTOSTART_POS    = 0;
  localparam int unsigned PROTECT_INIT_POS = 7;

  // counter geometry and reload values
  localparam int unsigned CNT_W = 15;
  localparam logic [CNT_W-1:0] LOAD_NORMAL  = 15'h7fff;
  localparam logic [CNT_W-1:0] LOAD_PROTECT = 15'h0fff;
  localparam logic [CNT_W-1:0] CNT_ZERO     = 15'h0000;
  localparam logic [CNT_W-1:0] CNT_ONE      = 15'h0001;

  // prescaler ratios (terminal counts)
  localparam int unsigned PRE_W = 7;
  localparam logic [PRE_W-1:0] PRE_LAST_16  = 7'h0f;
  localparam logic [PRE_W-1:0] PRE_LAST_128 = 7'h7f;
  localparam logic [PRE_W-1:0] PRE_ONE      = 7'h01;
  localparam logic [PRE_W-1:0] PRE_ZERO     = 7'h00;

  // refresh key bytes and option values
  localparam logic [7:0] KEY_ARM    = 8'h00;
  localparam logic [7:0] KEY_FIRE   = 8'hff;
  localparam logic [7:0] OPT_ERASED = 8'hff;
  localparam logic [7:0] BYTE_ZERO  = 8'h00;
  localparam logic [31:0] WORD_ZERO = 32'h0000_0000;

  typedef struct packed {
    logic          psel;
    logic          penable;
    logic          pwrite;
    logic [31:0]   paddr;
    logic [31:0]   pwdata;
  } apb_req_t;

  typedef struct packed {
    logic          pready;
    logic          pslverr;
    logic [31:0]   prdata;
  } apb_rsp_t;

  // reset / interrupt request towards the system
  typedef struct packed {
    logic          irq;
    logic          rst;
  } wdt_evt_t;

endpackage

//--- hw/wdt_sync.sv
// two-flop synchroniser for asynchronous inputs
`timescale 1ns/1ps
module wdt_sync #(
  parameter int unsigned W = 1
) (
  // clock and reset
  input  wire logic         mclk,
  input  wire logic         sys_rst,
  // levels
  input  wire logic [W-1:0] d,
  output logic      [W-1:0] q
);
  logic [W-1:0] meta_r;

  // the first stage feeds only the second; no reset, so the option pins
  // still pass while the device is held in reset and the latch sees them
  always_ff @(posedge mclk) begin
    meta_r <= d;
    q      <= meta_r;
  end
endmodule

//--- hw/wdt_prescaler.sv
// cpu-clock prescaler giving one tick every 16 or 128 cycles
`timescale 1ns/1ps
module wdt_prescaler (
  // clock and reset
  input  wire logic mclk,
  input  wire logic sys_rst,
  // control
  input  wire logic run,
  input  wire logic sel128,
  // output
  output logic      tick
);
  import wdt_pkg::*;

  logic [PRE_W-1:0] pre_r;
  wire  [PRE_W-1:0] last = sel128 ? PRE_LAST_128 : PRE_LAST_16;
  wire              wrap = run && (pre_r >= last);

  // only device reset or a wrap clears it, so a refresh may shorten the first period
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      pre_r <= PRE_ZERO;
    end else if (wrap) begin
      pre_r <= PRE_ZERO;
    end else if (run) begin
      pre_r <= pre_r + PRE_ONE;
    end
  end

  assign tick = wrap;

  a_prescale_kept: assert property (
    @(posedge mclk) disable iff (sys_rst)
    pre_r != PRE_ZERO && !wrap |=> pre_r != PRE_ZERO)
    else $error("prescaler cleared without reset or wrap");
endmodule

//--- hw/watchdog_counter.sv
// watchdog with protected count source, apb register access
//
// Chosen here: the APB slave port.
`timescale 1ns/1ps
module watchdog_counter (
  // clock and reset
  input  wire logic              mclk,
  input  wire logic              sys_rst,
  // register bus
  input  wire wdt_pkg::apb_req_t apbReq,
  output wdt_pkg::apb_rsp_t      apbRsp,
  // asynchronous inputs
  input  wire logic              loscClk,
  input  wire logic [7:0]        flashOpt,
  input  wire logic              flashErased,
  // cpu state, same clock
  input  wire logic              cpuWait,
  // outputs to the system
  output wdt_pkg::wdt_evt_t      wdtEvt,
  output logic                   stopReq,
  output logic                   loscOn
);
  import wdt_pkg::*;

  // synchronised pins
  logic [9:0] pinSync;
  logic       loscPrev_r;

  wdt_sync #(.W(10)) u_sync (
    .mclk    (mclk),
    .sys_rst (sys_rst),
    .d       ({loscClk, flashErased, flashOpt}),
    .q       (pinSync)
  );

  wire [7:0] optSrc   = pinSync[8] ? OPT_ERASED : pinSync[7:0];
  wire       loscLvl  = pinSync[9];
  wire       loscTick = loscLvl && !loscPrev_r;

  // state
  logic [CNT_W-1:0] cnt_r;
  logic             running_r;
  logic             protect_r;
  logic             armed_r;
  logic             presSel_r;
  logic             ufSel_r;
  logic             stopBit_r;
  logic             loscStop_r;
  logic [7:0]       optByte_r;
  apb_rsp_t         rsp_r;
  wdt_evt_t         evt_r;

  // register decode
  function automatic logic hit(input logic [31:0] a, input logic [AW-1:0] idx);
    hit = (a[AW+IDX_LSB-1:IDX_LSB] == idx) && (a[31:AW+IDX_LSB] == '0)
          && (a[IDX_LSB-1:0] == '0);
  endfunction

  // only the access cycle with pready high commits a write
  wire        setup   = apbReq.psel && !apbReq.penable;
  wire        wrEn    = apbReq.psel && apbReq.penable && rsp_r.pready && apbReq.pwrite;
  wire [31:0] pa      = apbReq.paddr;
  wire [7:0]  wb      = apbReq.pwdata[7:0];
  wire        selProc = hit(pa, IDX_PROC_MODE);
  wire        selClk  = hit(pa, IDX_CLK_MODE);
  wire        selRef  = hit(pa, IDX_REFRESH);
  wire        selSta  = hit(pa, IDX_START);
  wire        selCtl  = hit(pa, IDX_CTRL);
  wire        selCnt  = hit(pa, IDX_COUNT);
  wire        selPro  = hit(pa, IDX_PROTECT);
  wire        selOpt  = hit(pa, IDX_OPTION);
  wire        mapped  = selProc | selClk | selRef | selSta | selCtl | selCnt
                        | selPro | selOpt;

  // write strobes
  wire wrRef     = wrEn && selRef;
  wire wrStart   = wrEn && selSta;
  wire wrCtl     = wrEn && selCtl;
  wire wrProc    = wrEn && selProc;
  wire wrClk     = wrEn && selClk;
  wire protSet   = wrEn && selPro && wb[PROTECT_EN_POS] && !protect_r;
  wire refreshGo = wrRef && armed_r && (wb == KEY_FIRE);

  // counting
  // while unprotected, wait and stop freeze prescaler and counter alike; the held count resumes
  wire paused   = !protect_r && (cpuWait || stopBit_r);
  wire presRun  = running_r && !paused && !protect_r;
  wire presTick;

  wdt_prescaler u_pres (
    .mclk    (mclk),
    .sys_rst (sys_rst),
    .run     (presRun),
    .sel128  (presSel_r),
    .tick    (presTick)
  );

  wire              tick      = protect_r ? (running_r && loscTick) : presTick;
  wire              underflow = tick && (cnt_r == CNT_ZERO);
  wire [CNT_W-1:0]  reloadVal = protect_r ? LOAD_PROTECT : LOAD_NORMAL;
  wire              ufReset   = protect_r || ufSel_r;

  // read mux
  wire [7:0] rdCtl = {presSel_r, 7'h00};
  wire [7:0] rdProc = {5'h00, ufSel_r, 2'h0};
  wire [7:0] rdClk  = {3'h0, loscStop_r, 3'h0, stopBit_r};
  wire [7:0] rdPro = {protect_r, 7'h00};
  wire [31:0] rdData =
      selCtl ? {24'h000000, rdCtl} :
      selProc ? {24'h000000, rdProc} :
      selClk  ? {24'h000000, rdClk} :
      selSta ? {31'h00000000, running_r} :
      selCnt ? {17'h00000, cnt_r} :
      selPro ? {24'h000000, rdPro} :
      selOpt ? {24'h000000, optByte_r} : WORD_ZERO;

  // bus answer: ready in the cycle after setup, zero wait states
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      rsp_r <= '0;
    end else begin
      rsp_r.pready  <= setup;
      rsp_r.pslverr <= setup && !mapped;
      rsp_r.prdata  <= (setup && !apbReq.pwrite) ? rdData : WORD_ZERO;
    end
  end

  // option byte snapshot and oscillator edge
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      optByte_r  <= optSrc;
      loscPrev_r <= 1'b0;
    end else begin
      loscPrev_r <= loscLvl;
    end
  end

  // protection, start and refresh key
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      protect_r <= !optSrc[PROTECT_INIT_POS];
      running_r <= !optSrc[AUTOSTART_POS];
      armed_r   <= 1'b0;
    end else begin
      if (protSet) protect_r <= 1'b1;
      if (wrStart) running_r <= 1'b1;
      if (wrRef) armed_r <= (wb == KEY_ARM);
    end
  end

  // control bits; protection overrides software
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      presSel_r  <= 1'b0;
      ufSel_r    <= 1'b0;
      stopBit_r  <= 1'b0;
      loscStop_r <= 1'b0;
    end else begin
      if (wrCtl) presSel_r <= wb[PRESCALE_SEL_POS];
      if (protSet) begin
        ufSel_r    <= 1'b1;
        loscStop_r <= 1'b0;
      end else begin
        if (wrProc) ufSel_r <= wb[UF_RESET_SEL_POS];
        if (wrClk && !(protect_r && wb[LOSC_STOP_POS])) begin
          loscStop_r <= wb[LOSC_STOP_POS];
        end
      end
      if (wrClk && !(protect_r && wb[STOP_MODE_POS])) begin
        stopBit_r <= wb[STOP_MODE_POS];
      end
    end
  end

  // counter
  // protection entry wins over a refresh or underflow in the same cycle
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      cnt_r <= optSrc[PROTECT_INIT_POS] ? LOAD_NORMAL : LOAD_PROTECT;
    end else if (protSet) begin
      cnt_r <= LOAD_PROTECT;
    end else if (refreshGo || underflow) begin
      cnt_r <= reloadVal;
    end else if (tick) begin
      cnt_r <= cnt_r - CNT_ONE;
    end
  end

  // underflow events and pin outputs
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      evt_r   <= '0;
      stopReq <= 1'b0;
      loscOn  <= 1'b1;
    end else begin
      evt_r.irq <= underflow && !ufReset;
      evt_r.rst <= underflow && ufReset;
      stopReq   <= stopBit_r && !protect_r;
      loscOn    <= !loscStop_r;
    end
  end

  assign apbRsp = rsp_r;
  assign wdtEvt = evt_r;

  // checks
  default clocking cb @(posedge mclk); endclocking
  default disable iff (sys_rst);

  a_count_decrement: assert property (
    tick && !underflow && !protSet && !refreshGo |=> cnt_r == $past(cnt_r) - CNT_ONE)
    else $error("counter did not decrement on tick");
  a_refresh_reload: assert property (
    refreshGo && !protSet |=> cnt_r == (protect_r ? LOAD_PROTECT : LOAD_NORMAL))
    else $error("refresh pair did not reload counter");
  a_lone_fire: assert property (
    wrRef && !armed_r && !tick && !protSet |=> cnt_r == $past(cnt_r))
    else $error("unarmed refresh changed counter");
  a_underflow_reload: assert property (
    underflow && !protSet |=> cnt_r == ($past(protect_r) ? LOAD_PROTECT : LOAD_NORMAL))
    else $error("underflow did not reload");
  a_underflow_irq: assert property (
    underflow && !protect_r && !ufSel_r |=> wdtEvt.irq && !wdtEvt.rst)
    else $error("underflow interrupt missing");
  a_underflow_rst: assert property (
    underflow && (protect_r || ufSel_r) |=> wdtEvt.rst && !wdtEvt.irq)
    else $error("underflow reset missing");
  a_pause_hold: assert property (
    paused && !refreshGo && !protSet ##1 paused && !refreshGo && !protSet
      |-> $stable(cnt_r))
    else $error("counter moved while paused");
  a_protect_load: assert property (
    protSet |=> cnt_r == LOAD_PROTECT && ufSel_r && !loscStop_r && protect_r)
    else $error("protection entry side effects missing");
  a_protect_sticky: assert property (
    protect_r |=> protect_r)
    else $error("protection cleared without reset");
  a_stop_refused: assert property (
    protect_r && !stopBit_r |=> !stopBit_r ##1 !stopReq)
    else $error("stop mode entered while protected");
  a_stopped_hold: assert property (
    !running_r && !refreshGo && !protSet |=> cnt_r == $past(cnt_r))
    else $error("counter moved before start");

  // bus answer shape
  a_ready_after_setup: assert property (
    setup
    |=> apbRsp.pready)
    else $error("bus ready missing after setup");
  a_ready_single: assert property (
    !setup
    |=> !apbRsp.pready)
    else $error("bus ready without setup");
  a_unmapped_error: assert property (
    setup && !mapped
    |=> apbRsp.pslverr && apbRsp.prdata == WORD_ZERO)
    else $error("unmapped access not refused");
  a_mapped_no_error: assert property (
    setup && mapped
    |=> !apbRsp.pslverr)
    else $error("mapped access flagged as error");
  a_idle_no_data: assert property (
    !setup
    |=> apbRsp.prdata == WORD_ZERO)
    else $error("read data outside access cycle");

  // events, protection and pins
  a_events_exclusive: assert property (
    wdtEvt.irq
    |-> !wdtEvt.rst)
    else $error("interrupt and reset raised together");
  a_event_single: assert property (
    wdtEvt.rst || wdtEvt.irq
    |=> !wdtEvt.rst && !wdtEvt.irq)
    else $error("underflow event longer than one cycle");
  a_protect_no_irq: assert property (
    protect_r
    |=> !wdtEvt.irq)
    else $error("interrupt raised while protected");
  a_protect_no_stop: assert property (
    protect_r
    |=> !stopReq)
    else $error("stop request while protected");
  a_osc_stays_on: assert property (
    protect_r
    |-> !loscStop_r)
    else $error("oscillator stop bit set while protected");
  a_osc_pin_on: assert property (
    protect_r
    |=> loscOn)
    else $error("oscillator released while protected");
  a_start_sticky: assert property (
    running_r
    |=> running_r)
    else $error("counting stopped after start");
  a_option_fixed: assert property (
    1'b1
    |=> $stable(optByte_r))
    else $error("option byte changed without reset");
  a_prescaler_idle: assert property (
    protect_r
    |-> !presTick)
    else $error("prescaler ticked while protected");
  a_refresh_disarms: assert property (
    wrRef
    |=> armed_r == ($past(wb) == KEY_ARM))
    else $error("refresh key state wrong after write");
  a_wait_no_tick: assert property (
    !protect_r && cpuWait
    |-> !tick)
    else $error("tick during wait while unprotected");
  a_protect_wait_runs: assert property (
    protect_r && running_r && loscTick
    |-> tick)
    else $error("protected counting stopped");
  a_stop_ignored: assert property (
    wrClk && protect_r && wb[STOP_MODE_POS]
    |=> $stable(stopBit_r))
    else $error("stop bit written while protected");
  a_losc_ignored: assert property (
    wrClk && protect_r && wb[LOSC_STOP_POS]
    |=> $stable(loscStop_r))
    else $error("oscillator stop bit written while protected");

  c_refresh: cover property (armed_r ##[1:20] refreshGo);
  c_irq: cover property (wdtEvt.irq);
  c_protect: cover property (protect_r && underflow ##1 wdtEvt.rst);
  c_pause: cover property (running_r && paused ##1 !paused);
endmodule

//--- verification/testbench.sv
// self-checking bench for the watchdog block
`timescale 1ns/1ps
module testbench;
  import wdt_pkg::*;
  typedef struct {
    logic        w;
    logic [17:0] idx;
    logic [7:0]  wd;
    logic [31:0] ex;
    logic        err;
  } row_t;
  logic        mclk = 0;
  logic        sys_rst = 1;
  apb_req_t    apbReq = '0;
  apb_rsp_t    apbRsp;
  logic        loscClk = 0;
  logic        oscRun = 0;
  logic [7:0]  flashOpt = 8'h81;
  logic        flashErased = 0;
  logic        cpuWait = 1;
  wdt_evt_t    wdtEvt;
  logic        stopReq;
  logic        loscOn;
  int          mismatches = 0;
  int          checks_done = 0;
  int          cycles = 0;
  logic        irqSeen = 0;
  logic [31:0] rd;
  logic [31:0] prev;
  logic        er;
  int          n;
  // option 81h: unprotected, stopped after reset; count frozen by cpuWait
  row_t rows[13] = '{'{0, IDX_OPTION, 0, 32'h81, 0}, '{0, IDX_PROTECT, 0, 0, 0},
    '{0, IDX_START, 0, 0, 0}, '{0, IDX_COUNT, 0, 32'h7fff, 0}, '{1, IDX_OPTION, 0, 0, 0},
    '{0, IDX_OPTION, 0, 32'h81, 0}, '{1, IDX_COUNT, 8'h12, 0, 0},
    '{0, IDX_COUNT, 0, 32'h7fff, 0}, '{1, IDX_PROC_MODE, 8'h04, 0, 0},
    '{0, IDX_PROC_MODE, 0, 4, 0},
    '{0, 18'h00003, 0, 0, 1}, '{1, IDX_START, 8'h5a, 0, 0}, '{0, IDX_START, 0, 1, 0}};

  watchdog_counter DUT (.mclk(mclk), .sys_rst(sys_rst), .apbReq(apbReq), .apbRsp(apbRsp),
    .loscClk(loscClk), .flashOpt(flashOpt), .flashErased(flashErased), .cpuWait(cpuWait),
    .wdtEvt(wdtEvt), .stopReq(stopReq), .loscOn(loscOn));

  always #4 mclk = ~mclk;
  // oscillator held still when not in use; period 33 ns, unrelated to mclk
  always #16.5 loscClk = oscRun ? ~loscClk : 1'b0;

  task automatic give_verdict();
    $display("checks %0d mismatches %0d", checks_done, mismatches);
    if (mismatches == 0 && checks_done > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask

  always @(posedge mclk) begin
    cycles++;
    if (wdtEvt.irq === 1'b1) irqSeen = 1;
    if (cycles == 60000) begin
      mismatches++;
      give_verdict();
    end
  end

  task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] ex);
    checks_done++;
    if (seen !== ex) begin
      mismatches++;
      $display("BAD %s expected %h seen %h", nm, ex, seen);
    end
  endtask

  task automatic apb(input logic w, input logic [17:0] idx, input logic [7:0] wd);
    int k;
    k = 0;
    @(posedge mclk);
    apbReq <= '{psel: 1, penable: 0, pwrite: w, paddr: {12'h000, idx, 2'b00},
                pwdata: {24'h000000, wd}};
    @(posedge mclk);
    apbReq.penable <= 1'b1;
    do begin
      @(posedge mclk);
      k++;
    end while (apbRsp.pready !== 1'b1 && k < 50);
    rd = apbRsp.prdata;
    er = apbRsp.pslverr;
    apbReq <= '0;
    if (k >= 50) mismatches++;
  endtask

  task automatic reset_dut(input logic [7:0] opt, input logic erased);
    @(posedge mclk);
    flashOpt <= opt;
    flashErased <= erased;
    sys_rst <= 1'b1;
    repeat (20) @(posedge mclk);
    sys_rst <= 1'b0;
  endtask

  task automatic wait_rst(output int k);
    k = 0;
    do begin
      @(posedge mclk);
      k++;
    end while (wdtEvt.rst !== 1'b1 && k < 20000);
  endtask

  initial begin
    reset_dut(8'h81, 0);
    foreach (rows[i]) begin
      apb(rows[i].w, rows[i].idx, rows[i].wd);
      check("pslverr", {31'h0, er}, {31'h0, rows[i].err});
      if (!rows[i].w) check("rdata", rd, rows[i].ex);
    end
    $display("test table done");
    // prescaler phase is unknown, hence one tick of slack
    cpuWait <= 1'b0;
    repeat (320) @(posedge mclk);
    cpuWait <= 1'b1;
    apb(0, IDX_COUNT, 0);
    n = 32'h7fff - rd;
    check("ticks16", (n >= 19 && n <= 21), 1);
    prev = rd;
    apb(1, IDX_CTRL, 8'h80);
    cpuWait <= 1'b0;
    repeat (640) @(posedge mclk);
    cpuWait <= 1'b1;
    apb(0, IDX_COUNT, 0);
    n = prev - rd;
    check("ticks128", (n >= 4 && n <= 6), 1);
    prev = rd;
    repeat (300) @(posedge mclk);
    apb(0, IDX_COUNT, 0);
    check("paused", rd, prev);
    $display("test counting done");
    apb(1, IDX_REFRESH, 8'h00);
    apb(1, IDX_REFRESH, 8'h11);
    apb(1, IDX_REFRESH, 8'hff);
    apb(0, IDX_COUNT, 0);
    check("badKey", rd, prev);
    apb(1, IDX_REFRESH, 8'h00);
    apb(1, IDX_REFRESH, 8'hff);
    apb(0, IDX_COUNT, 0);
    check("refresh", rd, 32'h7fff);
    $display("test refresh done");
    apb(1, IDX_PROC_MODE, 8'h00);
    apb(1, IDX_CLK_MODE, 8'h11);
    // stopReq and loscOn follow the bits one registered cycle later
    repeat (2) @(posedge mclk);
    check("stopReq", {31'h0, stopReq}, 1);
    check("loscOff", {31'h0, loscOn}, 0);
    apb(1, IDX_PROTECT, 8'h80);
    apb(0, IDX_COUNT, 0);
    check("protLoad", rd, 32'h0fff);
    apb(0, IDX_PROC_MODE, 0);
    check("procMode", rd, 32'h04);
    apb(0, IDX_CLK_MODE, 0);
    check("clkMode", rd, 32'h01);
    check("loscOn", {31'h0, loscOn}, 1);
    check("noStop", {31'h0, stopReq}, 0);
    apb(1, IDX_CLK_MODE, 8'h11);
    apb(0, IDX_CLK_MODE, 0);
    check("clkModeLock", rd, 32'h01);
    apb(1, IDX_PROTECT, 8'h00);
    apb(0, IDX_PROTECT, 0);
    check("protSticky", rd, 32'h80);
    $display("test protection done");
    // 4096 ticks of 33 ns make 16896 mclk cycles; cpuWait stays high
    oscRun = 1;
    wait_rst(n);
    wait_rst(n);
    check("period", (n >= 16894 && n <= 16898), 1);
    @(posedge mclk);
    check("rstPulse", {31'h0, wdtEvt.rst}, 0);
    check("noIrq", {31'h0, irqSeen}, 0);
    oscRun = 0;
    $display("test underflow done");
    reset_dut(8'h7e, 0);
    apb(0, IDX_PROTECT, 0);
    check("protInit", rd, 32'h80);
    apb(0, IDX_START, 0);
    check("autostart", rd, 32'h01);
    reset_dut(8'h00, 1);
    apb(0, IDX_OPTION, 0);
    check("erased", rd, 32'hff);
    apb(0, IDX_PROTECT, 0);
    check("erasedProt", rd, 32'h00);
    apb(0, IDX_START, 0);
    check("erasedStop", rd, 32'h00);
    $display("test option done");
    give_verdict();
  end
endmodule
